// [design/hpa_pkg.sv]
package hpa_pkg;
   // ==========================================================
   // Microprocessor-side register selects
   localparam logic [3:0] MP_HOLD_HI  = 4'h0;
   localparam logic [3:0] MP_HOLD_LO  = 4'h1;
   localparam logic [3:0] MP_FILE_ADR = 4'h2;
   localparam logic [3:0] MP_PORT_SEL = 4'h3;
   localparam logic [3:0] MP_CSR      = 4'h4;
   localparam logic [3:0] MP_ERR      = 4'h5;
   localparam logic [3:0] MP_EVT      = 4'h6;
   localparam logic [3:0] MP_DMA_LO   = 4'h7;
   localparam logic [3:0] MP_DMA_HI   = 4'h8;
   localparam logic [3:0] MP_VECTOR   = 4'h9;
   localparam logic [3:0] MP_IRQ      = 4'ha;
   localparam logic [3:0] MP_DRV_STAT = 4'hb;
   // ==========================================================
   // File address register fields
   localparam int FA_DIR = 6;
   localparam int FA_W   = 6;
   // ==========================================================
   // Control status register fields
   localparam int CSR_INT_EN  = 0;
   localparam int CSR_INC_INH = 1;
   localparam int CSR_GO      = 2;
   localparam int CSR_PWR_LOW = 3;
   localparam int CSR_BUSY    = 6;
   localparam int CSR_READY   = 7;
   localparam logic [7:0] CSR_RESET = 8'h00;
   localparam logic [7:0] CSR_MCLR  = 8'h80;
   // ==========================================================
   // Error and event flag bits
   localparam int ERR_TIMEOUT = 0;
   localparam int EVT_ANY_ERR = 0;
   localparam int EVT_SYS_RST = 1;
   localparam int EVT_CMD     = 2;
   localparam int EVT_MCLR    = 3;
   localparam int EVT_PWR_LOW = 4;
   localparam logic [5:0] CMD_LOC = 6'h00;
   // ==========================================================
   // Timing
   localparam int CLK_MHZ        = 200;
   localparam int FILE_ACCESS_NS = 100;
   localparam int FILE_ACCESS_CYC = FILE_ACCESS_NS * CLK_MHZ / 1000 - 1;
   localparam int XFER_TMO_NS    = 10000;
   localparam int XFER_TMO_CYC   = XFER_TMO_NS * CLK_MHZ / 1000;
   // ==========================================================
   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_REQ  = 3'b001,
      S_ADDR = 3'b010,
      S_STB  = 3'b011,
      S_ACKL = 3'b100,
      S_REL  = 3'b101
   } hpa_dma_e;
endpackage : hpa_pkg

// [design/hpa_adapter.sv]
`timescale 1ns/100ps
// ==========================================================
// Word FIFO between the controller data path and the DMA engine
module hpa_fifo #(
   parameter int W = 16,
   parameter int D = 8
) (
   input  wire logic         clk_i,
   input  wire logic         nrst_i,
   input  wire logic         in_valid_i,
   output logic              in_ready_o,
   input  wire logic [W-1:0] in_data_i,
   output logic              out_valid_o,
   input  wire logic         out_ready_i,
   output logic [W-1:0]      out_data_o
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW:0]  wp;
   logic [AW:0]  rp;
   logic         push;
   logic         pop;

   assign out_valid_o = (wp != rp);
   assign in_ready_o  = (wp[AW-1:0] != rp[AW-1:0]) || (wp[AW] == rp[AW]);
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;
   assign out_data_o  = mem[rp[AW-1:0]];

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wp[AW-1:0]] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         wp <= '0;
         rp <= '0;
      end else begin
         if (push) begin
            wp <= wp + 1'b1;
         end
         if (pop) begin
            rp <= rp + 1'b1;
         end
      end
   end
endmodule : hpa_fifo

// Notes on behaviour
// - Drive address before word, then increment
// - Data path bound to one adapter
// - Bursts 1 to 16, release if others
// - No other requester: keep bus, burst again
// - Host interrupt and vector only from microprocessor
// - Host interrupt has software enable
// - Errors flagged; OR sets summary event
// - Async occurrences set event flags
// - Flags stay set until microprocessor clears
// - DMA counter loaded by microprocessor, hidden from host
// - Two holding bytes, 6-bit file address
// - 2-bit port select, ports 0 to 3
// - Direction 0 reads whole word into holders
// - Direction 1 writes both holders to file
// - Simultaneous file requests served in turn
// - Each file access under 100 ns
// - Byte-wide host makes file access byte-wide
// - Power-low bit plus host interrupt
// - Host power-low flags event, aborts transfer
// - Per-drive power loss status
// - Master clear flags event, resets control
module hpa_adapter
   import hpa_pkg::*;
#(
   parameter logic [1:0] PORT_ID = 2'h0,
   parameter int         FIFO_D  = 8
) (
   input  wire logic        clk_i,
   input  wire logic        nrst_i,
   input  wire logic        mp_cs_i,
   input  wire logic        mp_we_i,
   input  wire logic [3:0]  mp_addr_i,
   input  wire logic [7:0]  mp_wdata_i,
   output logic [7:0]       mp_rdata_o,
   input  wire logic        host_req_i,
   input  wire logic        host_we_i,
   input  wire logic [5:0]  host_addr_i,
   input  wire logic [15:0] host_wdata_i,
   output logic [15:0]      host_rdata_o,
   output logic             host_ack_o,
   input  wire logic        host_mclr_i,
   input  wire logic        host_sys_rst_i,
   input  wire logic        host_pwr_low_i,
   output logic             host_irq_o,
   output logic [7:0]       host_vector_o,
   input  wire logic        host_iack_i,
   input  wire logic        byte_host_i,
   input  wire logic [3:0]  burst_len_i,
   input  wire logic [3:0]  drv_pwr_loss_i,
   input  wire logic        dp_valid_i,
   output logic             dp_ready_o,
   input  wire logic [15:0] dp_data_i,
   output logic             dma_bus_req_o,
   input  wire logic        dma_grant_i,
   input  wire logic        dma_other_req_i,
   output logic [15:0]      dma_addr_o,
   output logic [15:0]      dma_data_o,
   output logic             dma_strobe_o,
   input  wire logic        dma_ack_i,
   output logic             sector_abort_o,
   output logic             pwr_low_o
);
   // ==========================================================
   // Pin synchronisers
   localparam int NS = 12;
   logic [NS-1:0] s1;
   logic [NS-1:0] s2;
   logic [2:0]    s3;
   logic host_req_s, mclr_s, sysrst_s, pwrlow_s, iack_s;
   logic grant_s, other_s, ack_s;
   logic [3:0] drv_s;

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
      end else begin
         s1 <= {drv_pwr_loss_i, dma_ack_i, dma_other_req_i, dma_grant_i,
                host_iack_i, host_pwr_low_i, host_sys_rst_i, host_mclr_i,
                host_req_i};
         s2 <= s1;
         s3 <= {s2[3], s2[2], s2[1]};
      end
   end
   assign {drv_s, ack_s, other_s, grant_s, iack_s, pwrlow_s, sysrst_s,
           mclr_s, host_req_s} = s2;
   wire mclr_p   = mclr_s && !s3[0];
   wire sysrst_p = sysrst_s && !s3[1];
   wire pwrlow_p = pwrlow_s && !s3[2];

   // ==========================================================
   // Microprocessor register writes
   logic [7:0] hold_hi, hold_lo, csr, err, evt, vector;
   logic [6:0] file_adr;
   logic [1:0] port_sel;
   logic [15:0] dma_cnt;
   logic [3:0] drv_stat;
   logic irq_pend, mp_pend, host_pend, last_host, busy;
   logic dir_wr, to_err;
   wire  sel  = (port_sel == PORT_ID);
   wire  mwr  = mp_cs_i && mp_we_i && (sel || mp_addr_i == MP_PORT_SEL);
   wire  wr_ha = mwr && mp_addr_i == MP_FILE_ADR;
   wire  irq_wr = mwr && mp_addr_i == MP_IRQ;
   wire  g_mp, g_host;

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         port_sel <= '0;
         file_adr <= '0;
         vector   <= '0;
      end else if (mwr) begin
         case (mp_addr_i)
            MP_PORT_SEL: port_sel <= mp_wdata_i[1:0];
            MP_FILE_ADR: file_adr <= mp_wdata_i[6:0];
            MP_VECTOR:   vector   <= mp_wdata_i;
            default: ;
         endcase
      end
   end

   // ==========================================================
   // Control status register
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         csr <= CSR_RESET;
      end else if (mclr_p) begin
         csr <= CSR_MCLR;
      end else if (mwr && mp_addr_i == MP_CSR) begin
         csr <= mp_wdata_i;
      end
   end
   assign pwr_low_o = csr[CSR_PWR_LOW];

   // ==========================================================
   // File access arbitration: one cycle per access
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         mp_pend <= 1'b0;
      end else if (wr_ha) begin
         mp_pend <= 1'b1;
      end else if (g_mp) begin
         mp_pend <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         host_pend  <= 1'b0;
         host_ack_o <= 1'b0;
      end else begin
         if (g_host) begin
            host_pend  <= 1'b0;
            host_ack_o <= 1'b1;
         end else if (host_req_s && !host_ack_o && !host_pend) begin
            host_pend <= 1'b1;
         end
         if (!host_req_s) begin
            host_ack_o <= 1'b0;
         end
      end
   end

   // Priority flips after each access so neither side starves
   assign g_host = host_pend && (!mp_pend || !last_host);
   assign g_mp   = mp_pend && !g_host;

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         last_host <= 1'b0;
      end else if (g_host || g_mp) begin
         last_host <= g_host;
      end
   end

   logic [15:0] file [64];
   assign dir_wr = file_adr[FA_DIR];

   always_ff @(posedge clk_i) begin
      if (g_host && host_we_i) begin
         file[host_addr_i] <= host_wdata_i;
      end else if (g_mp && dir_wr) begin
         if (byte_host_i) begin
            file[file_adr[FA_W-1:0]][7:0] <= hold_lo;
         end else begin
            file[file_adr[FA_W-1:0]] <= {hold_hi, hold_lo};
         end
      end
   end

   // Host data never includes the DMA counter
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         host_rdata_o <= '0;
      end else if (g_host) begin
         host_rdata_o <= file[host_addr_i];
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         hold_hi <= '0;
         hold_lo <= '0;
      end else if (g_mp && !dir_wr) begin
         hold_lo <= file[file_adr[FA_W-1:0]][7:0];
         if (!byte_host_i) begin
            hold_hi <= file[file_adr[FA_W-1:0]][15:8];
         end
      end else if (mwr && mp_addr_i == MP_HOLD_HI) begin
         hold_hi <= mp_wdata_i;
      end else if (mwr && mp_addr_i == MP_HOLD_LO) begin
         hold_lo <= mp_wdata_i;
      end
   end
   assign busy = mp_pend;

   // ==========================================================
   // Error and event flags: set beats clear
   wire cmd_p = g_host && host_we_i && host_addr_i == CMD_LOC;
   wire [7:0] err_set = 8'(to_err) << ERR_TIMEOUT;
   wire [7:0] evt_set = (8'(|err) << EVT_ANY_ERR) |
                        (8'(sysrst_p) << EVT_SYS_RST) |
                        (8'(cmd_p) << EVT_CMD) |
                        (8'(mclr_p) << EVT_MCLR) |
                        (8'(pwrlow_p) << EVT_PWR_LOW);
   wire [7:0] err_clr = (mwr && mp_addr_i == MP_ERR) ? mp_wdata_i : 8'h00;
   wire [7:0] evt_clr = (mwr && mp_addr_i == MP_EVT) ? mp_wdata_i : 8'h00;

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         err <= '0;
         evt <= '0;
      end else begin
         err <= (err & ~err_clr) | err_set;
         evt <= (evt & ~evt_clr) | evt_set;
      end
   end

   // A transfer stops at the sector end the controller chooses
   assign sector_abort_o = evt[EVT_PWR_LOW] && csr[CSR_GO];

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         drv_stat <= '0;
      end else begin
         drv_stat <= (drv_stat & ~((mwr && mp_addr_i == MP_DRV_STAT) ?
                     mp_wdata_i[3:0] : 4'h0)) | drv_s;
      end
   end

   // ==========================================================
   // Host interrupt, raised only by a microprocessor write
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         irq_pend <= 1'b0;
      end else if (irq_wr) begin
         irq_pend <= 1'b1;
      end else if (iack_s) begin
         irq_pend <= 1'b0;
      end
   end
   assign host_irq_o    = irq_pend && csr[CSR_INT_EN];
   assign host_vector_o = vector;

   // ==========================================================
   // Microprocessor read data
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         mp_rdata_o <= '0;
      end else if (mp_cs_i && !mp_we_i) begin
         case (mp_addr_i)
            MP_HOLD_HI:  mp_rdata_o <= hold_hi;
            MP_HOLD_LO:  mp_rdata_o <= hold_lo;
            MP_FILE_ADR: mp_rdata_o <= {1'b0, file_adr};
            MP_PORT_SEL: mp_rdata_o <= {6'h00, port_sel};
            MP_CSR:      mp_rdata_o <= csr | (8'(busy) << CSR_BUSY);
            MP_ERR:      mp_rdata_o <= err;
            MP_EVT:      mp_rdata_o <= evt;
            MP_DMA_LO:   mp_rdata_o <= dma_cnt[7:0];
            MP_DMA_HI:   mp_rdata_o <= dma_cnt[15:8];
            MP_VECTOR:   mp_rdata_o <= vector;
            MP_DRV_STAT: mp_rdata_o <= {4'h0, drv_stat};
            default:     mp_rdata_o <= 8'h00;
         endcase
      end
   end

   // ==========================================================
   // Data path: bound to this adapter while go is set and port select equals PORT_ID
   logic        f_valid, f_pop;
   logic [15:0] f_data;
   wire         linked = csr[CSR_GO] && sel;
   logic        dp_rdy;
   assign dp_ready_o = dp_rdy && linked;

   hpa_fifo #(.W(16), .D(FIFO_D)) u_fifo (
      .clk_i       (clk_i),
      .nrst_i      (nrst_i),
      .in_valid_i  (dp_valid_i && linked),
      .in_ready_o  (dp_rdy),
      .in_data_i   (dp_data_i),
      .out_valid_o (f_valid),
      .out_ready_i (f_pop),
      .out_data_o  (f_data)
   );

   // ==========================================================
   // DMA burst engine
   hpa_dma_e st;
   logic [3:0]  bcnt;
   logic [11:0] tmo;
   wire  go = csr[CSR_GO];
   assign f_pop = (st == S_ADDR);
   assign to_err = (st == S_STB) && !ack_s && tmo == 12'(XFER_TMO_CYC);

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         st <= S_IDLE;
      end else begin
         case (st)
            S_IDLE: if (go && f_valid) st <= S_REQ;
            S_REQ:  if (grant_s) st <= S_ADDR;
            S_ADDR: st <= S_STB;
            S_STB: begin
               if (ack_s) begin
                  st <= S_ACKL;
               end else if (to_err) begin
                  st <= S_REL;
               end
            end
            S_ACKL: begin
               if (!ack_s) begin
                  if (!go || !f_valid || (bcnt == 4'h0 && other_s)) begin
                     st <= S_REL;
                  end else begin
                     st <= S_ADDR;
                  end
               end
            end
            S_REL:  st <= S_IDLE;
            default: st <= S_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         bcnt <= '0;
      end else if (st == S_REQ && grant_s) begin
         bcnt <= burst_len_i;
      end else if (st == S_ACKL && !ack_s) begin
         bcnt <= (bcnt == 4'h0) ? burst_len_i : bcnt - 4'h1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         tmo <= '0;
      end else if (st == S_STB) begin
         tmo <= tmo + 12'h001;
      end else begin
         tmo <= '0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         dma_cnt <= '0;
      end else if (mwr && mp_addr_i == MP_DMA_LO) begin
         dma_cnt[7:0] <= mp_wdata_i;
      end else if (mwr && mp_addr_i == MP_DMA_HI) begin
         dma_cnt[15:8] <= mp_wdata_i;
      end else if (st == S_STB && ack_s && !csr[CSR_INC_INH]) begin
         dma_cnt <= dma_cnt + 16'h0001;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         dma_data_o <= '0;
      end else if (st == S_ADDR) begin
         dma_data_o <= f_data;
      end
   end

   assign dma_addr_o    = dma_cnt;
   assign dma_strobe_o  = (st == S_STB);
   assign dma_bus_req_o = (st != S_IDLE) && (st != S_REL);

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);

   sequence both_req_s;
      host_pend && mp_pend;
   endsequence
   sequence word_done_s;
      st == S_STB && ack_s;
   endsequence

   arb_turns_a: assert property (both_req_s |=> ##[0:1] !mp_pend)
      else $error("waiting access not served in turn");
   localparam int ACC_MAX = FILE_ACCESS_CYC;
   file_time_a: assert property (mp_pend && !host_pend |->
      ##[1:ACC_MAX] !mp_pend)
      else $error("file access too slow");
   addr_inc_a: assert property ((word_done_s and (!csr[CSR_INC_INH] &&
      !mwr)) |=> dma_addr_o == $past(dma_addr_o) + 16'h0001)
      else $error("address not advanced");
   addr_hold_a: assert property ((word_done_s and (csr[CSR_INC_INH] &&
      !mwr)) |=> $stable(dma_addr_o))
      else $error("address moved while inhibited");
   burst_rel_a: assert property (st == S_ACKL && !ack_s && bcnt == 4'h0
      && other_s |=> !dma_bus_req_o)
      else $error("bus kept despite other requester");
   burst_keep_a: assert property (st == S_ACKL && !ack_s && go && f_valid
      && !other_s |=> dma_bus_req_o)
      else $error("bus dropped with no other requester");
   irq_src_a: assert property ($rose(irq_pend) |->
      $past(irq_wr))
      else $error("interrupt without microprocessor");
   irq_en_a: assert property (!csr[CSR_INT_EN] |-> !host_irq_o)
      else $error("interrupt while disabled");
   err_sum_a: assert property (|err |=> evt[EVT_ANY_ERR])
      else $error("error summary missing");
   evt_stick_a: assert property (evt[EVT_MCLR] && !(mwr && mp_addr_i ==
      MP_EVT) |=> evt[EVT_MCLR])
      else $error("event flag lost");
   mclr_csr_a: assert property (mclr_p |=> csr == CSR_MCLR
      && evt[EVT_MCLR])
      else $error("master clear effect wrong");
   link_one_a: assert property (dp_ready_o |-> go && sel)
      else $error("data path taken while unbound");
endmodule : hpa_adapter

// [bench/hpa_dma_model.sv]
`timescale 1ns/100ps
// ==========================================================
// Far side of the DMA bus: grant, slow or missing ack, rivals
module hpa_dma_model (
   input  wire logic clk_i,
   input  wire logic bus_req_i,
   input  wire logic strobe_i,
   input  wire logic hold_i,
   input  wire logic mute_i,
   output logic      grant_o,
   output logic      ack_o,
   output logic      other_o
);
   int dly = 0;
   initial begin
      grant_o = 1'b0;
      ack_o = 1'b0;
      other_o = 1'b0;
   end
   always @(posedge clk_i) begin
      #1;
      grant_o = bus_req_i & ~hold_i;
      // Rival requests are redrawn at random every cycle so both burst endings occur
      other_o = 1'($urandom_range(1, 0));
      if (strobe_i & ~ack_o & ~mute_i) begin
         if (dly == 0) begin
            dly = $urandom_range(3, 1);
         end else begin
            dly = dly - 1;
            ack_o = (dly == 0);
         end
      end else if (!strobe_i) begin
         ack_o = 1'b0;
      end
   end
endmodule : hpa_dma_model

// [bench/tb.sv]
`timescale 1ns/100ps
module tb;
   import hpa_pkg::*;
   logic        clk_i = 1'b0;
   logic        nrst_i = 1'b0;
   logic        cs = 0, we = 0, hreq = 0, hwe = 0, mclr = 0, srst = 0;
   logic        plow = 0, iack = 0, dval = 0, hold = 1, mute = 0, sp = 0;
   logic        bh = 0;
   logic [3:0]  ma = 0, blen = 0, dpl = 0;
   logic [7:0]  mw = 0, mr, vec, e, v;
   logic [5:0]  ha = 0, loc;
   logic [15:0] hw = 0, dd = 0, hr, hrd, da, dq, t, u, base;
   logic        hack, irq, drdy, breq, gnt, bak, oth, stb, sab, pwl;
   logic [15:0] got_a[$], got_d[$], put_d[$];
   int          miscompares = 0, num_checks = 0, k, n;
   always #2.5 clk_i = ~clk_i;
   hpa_adapter #(.PORT_ID(2'h0), .FIFO_D(8)) dut (
      .clk_i(clk_i), .nrst_i(nrst_i), .mp_cs_i(cs), .mp_we_i(we),
      .mp_addr_i(ma), .mp_wdata_i(mw), .mp_rdata_o(mr),
      .host_req_i(hreq), .host_we_i(hwe), .host_addr_i(ha),
      .host_wdata_i(hw), .host_rdata_o(hr), .host_ack_o(hack),
      .host_mclr_i(mclr), .host_sys_rst_i(srst),
      .host_pwr_low_i(plow), .host_irq_o(irq), .host_vector_o(vec),
      .host_iack_i(iack), .byte_host_i(bh), .burst_len_i(blen),
      .drv_pwr_loss_i(dpl), .dp_valid_i(dval), .dp_ready_o(drdy),
      .dp_data_i(dd), .dma_bus_req_o(breq), .dma_grant_i(gnt),
      .dma_other_req_i(oth), .dma_addr_o(da), .dma_data_o(dq),
      .dma_strobe_o(stb), .dma_ack_i(bak), .sector_abort_o(sab),
      .pwr_low_o(pwl)
   );
   hpa_dma_model far (
      .clk_i(clk_i), .bus_req_i(breq), .strobe_i(stb), .hold_i(hold),
      .mute_i(mute), .grant_o(gnt), .ack_o(bak), .other_o(oth)
   );
   // ==========================================================
   // Shared tasks
   task automatic chk(input logic [15:0] g, input logic [15:0] x);
      num_checks++;
      if (g !== x) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, g, x);
      end
   endtask : chk
   task automatic mp(input logic w, input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_i);
      #1;
      {cs, we, ma, mw} = {1'b1, w, a, d};
      @(posedge clk_i);
      #1;
      cs = 1'b0;
   endtask : mp
   task automatic rd(input logic [3:0] a, input logic [7:0] x);
      mp(1'b0, a, 8'h00);
      chk({8'h00, mr}, {8'h00, x});
   endtask : rd
   task automatic hx(input logic w, input logic [5:0] a, input logic [15:0] d);
      int m;
      m = 0;
      @(posedge clk_i);
      #1;
      {hreq, hwe, ha, hw} = {1'b1, w, a, d};
      // Request held until ack is sampled high, then dropped
      while (hack !== 1'b1 && m < 30) begin
         @(posedge clk_i);
         #1;
         m++;
      end
      hrd = hr;
      hreq = 1'b0;
      while (hack !== 1'b0 && m < 60) begin
         @(posedge clk_i);
         #1;
         m++;
      end
   endtask : hx
   task automatic pause(input int c);
      repeat (c) @(posedge clk_i);
      #1;
   endtask : pause
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : tally_and_finish
   // ==========================================================
   // Capture address and data at the first cycle of each strobe
   always @(posedge clk_i) begin
      #1;
      if (stb === 1'b1 && sp !== 1'b1) begin
         got_a.push_back(da);
         got_d.push_back(dq);
      end
      sp = stb;
   end
   initial begin
      #100000;
      miscompares++;
      tally_and_finish();
   end
   // ==========================================================
   // Main sequence
   initial begin
      void'($urandom(32'h947e));
      blen = 4'($urandom_range(15, 0));
      pause(12);
      nrst_i = 1'b1;
      pause(3);
      loc = 6'($urandom_range(31, 1) * 2);
      t = 16'($urandom);
      u = 16'($urandom);
      mp(1'b1, MP_HOLD_HI, t[15:8]);
      mp(1'b1, MP_HOLD_LO, t[7:0]);
      // Host and microprocessor collide on the file
      fork
         hx(1'b1, loc + 6'h1, u);
         begin
            pause(2);
            mp(1'b1, MP_FILE_ADR, {2'b01, loc});
         end
      join
      pause(4);
      mp(1'b1, MP_FILE_ADR, {2'b00, loc + 6'h1});
      pause(4);
      rd(MP_HOLD_HI, u[15:8]);
      rd(MP_HOLD_LO, u[7:0]);
      hx(1'b0, loc, 16'h0000);
      chk(hrd, t);
      // Byte-wide host: only the low byte moves either way
      bh = 1'b1;
      mp(1'b1, MP_HOLD_HI, ~t[15:8]);
      mp(1'b1, MP_HOLD_LO, u[15:8]);
      mp(1'b1, MP_FILE_ADR, {2'b01, loc});
      pause(4);
      hx(1'b0, loc, 16'h0000);
      chk(hrd, {t[15:8], u[15:8]});
      mp(1'b1, MP_HOLD_LO, 8'h00);
      mp(1'b1, MP_FILE_ADR, {2'b00, loc});
      pause(4);
      rd(MP_HOLD_HI, ~t[15:8]);
      rd(MP_HOLD_LO, u[15:8]);
      bh = 1'b0;
      $display("test file done");
      hx(1'b1, CMD_LOC, 16'h0001);
      k = $urandom_range(3, 0);
      {srst, plow, dpl} = {2'b11, 4'(1 << k)};
      pause(4);
      {srst, plow, dpl} = 6'h00;
      pause(4);
      e = (8'h01 << EVT_CMD) | (8'h01 << EVT_SYS_RST) | (8'h01 << EVT_PWR_LOW);
      rd(MP_EVT, e);
      rd(MP_DRV_STAT, 8'(1 << k));
      mp(1'b1, MP_CSR, 8'h01 << CSR_GO);
      chk({15'h0000, sab}, 16'h0001);
      mp(1'b1, MP_EVT, e & ~(8'h01 << EVT_CMD));
      rd(MP_EVT, 8'h01 << EVT_CMD);
      mp(1'b1, MP_EVT, 8'hff);
      $display("test events done");
      mp(1'b1, MP_CSR, 8'h0b);
      chk({15'h0000, pwl}, 16'h0001);
      mclr = 1'b1;
      pause(4);
      mclr = 1'b0;
      pause(4);
      rd(MP_CSR, CSR_MCLR);
      rd(MP_EVT, 8'h01 << EVT_MCLR);
      mp(1'b1, MP_EVT, 8'hff);
      v = 8'($urandom);
      mp(1'b1, MP_VECTOR, v);
      mp(1'b1, MP_CSR, 8'h00);
      mp(1'b1, MP_IRQ, 8'h01);
      chk({15'h0000, irq}, 16'h0000);
      mp(1'b1, MP_CSR, 8'h01);
      chk({15'h0000, irq}, 16'h0001);
      chk({8'h00, vec}, {8'h00, v});
      iack = 1'b1;
      pause(4);
      iack = 1'b0;
      chk({15'h0000, irq}, 16'h0000);
      $display("test interrupt done");
      base = 16'($urandom);
      mp(1'b1, MP_DMA_LO, base[7:0]);
      mp(1'b1, MP_DMA_HI, base[15:8]);
      mp(1'b1, MP_PORT_SEL, 8'h02);
      mp(1'b1, MP_CSR, 8'h01 << CSR_GO);
      chk({15'h0000, drdy}, 16'h0000);
      mp(1'b1, MP_PORT_SEL, 8'h00);
      mp(1'b1, MP_CSR, 8'h01 << CSR_GO);
      // Grant withheld so the FIFO must fill and refuse
      dval = 1'b1;
      for (int i = 0; i < 12; i++) begin
         dd = 16'($urandom);
         if (drdy === 1'b1) put_d.push_back(dd);
         pause(1);
      end
      dval = 1'b0;
      chk(16'(put_d.size()), 16'h0008);
      hold = 1'b0;
      n = 0;
      while (got_a.size() < put_d.size() && n < 2000) begin
         pause(1);
         n++;
      end
      pause(20);
      chk(16'(got_a.size()), 16'(put_d.size()));
      foreach (put_d[i]) begin
         chk(got_a[i], base + 16'(i));
         chk(got_d[i], put_d[i]);
      end
      t = base + 16'h0008;
      rd(MP_DMA_LO, t[7:0]);
      rd(MP_DMA_HI, t[15:8]);
      $display("test dma done");
      // One word with the address advance inhibited
      mp(1'b1, MP_CSR, (8'h01 << CSR_GO) | (8'h01 << CSR_INC_INH));
      dd = 16'($urandom);
      dval = 1'b1;
      pause(1);
      dval = 1'b0;
      pause(40);
      chk(got_d[8], dd);
      chk(got_a[8], t);
      rd(MP_DMA_LO, t[7:0]);
      $display("test inhibit done");
      mute = 1'b1;
      dd = 16'($urandom);
      dval = 1'b1;
      pause(1);
      dval = 1'b0;
      pause(XFER_TMO_CYC + 100);
      rd(MP_ERR, 8'h01 << ERR_TIMEOUT);
      rd(MP_EVT, 8'h01 << EVT_ANY_ERR);
      mute = 1'b0;
      $display("test timeout done");
      tally_and_finish();
   end
endmodule : tb
